//--- ptm_pkg.sv
/*
 * constants for the port one pin-mux and tone-output block: register
 * offsets, write masks, reset values, field positions and divider counts.
 * assumes nothing of its surroundings; imported whole by the tone, port and bench modules.
 */
package ptm_pkg;

	// ==========================================================
	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] OFS_MODE1 = 8'h00; // first_mode_register
	localparam logic [7:0] OFS_DIR   = 8'h04; // pin_direction_ctrl
	localparam logic [7:0] OFS_DATA  = 8'h08; // pin_data_latch
	localparam logic [7:0] OFS_TONE  = 8'h0c; // tone_output_mode
	localparam logic [7:0] OFS_EDGE  = 8'h10; // edge_select_register

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_MODE1 = 8'h0c;
	localparam logic [7:0] RST_DIR   = 8'hcc;
	localparam logic [7:0] RST_DATA  = 8'h0c;
	localparam logic [7:0] RST_TONE  = 8'h0f;
	localparam logic [7:0] RST_EDGE  = 8'h00;

	// ==========================================================
	// writable bits; every other bit keeps its reset value
	localparam logic [7:0] WR_MODE1 = 8'hf3;
	localparam logic [7:0] WR_DIR   = 8'h33;
	localparam logic [7:0] WR_DATA  = 8'h33;
	localparam logic [7:0] WR_TONE  = 8'hf0;
	localparam logic [7:0] WR_EDGE  = 8'h33;
	localparam logic [7:0] IN_ONLY  = 8'hc0; // pins 7 and 6
	localparam logic [7:0] DIR_RD   = 8'hff; // write-only reads back ones

	// ==========================================================
	// field positions
	localparam int POS_INT0  = 0; // pin0_interrupt_select
	localparam int POS_INT1  = 1;
	localparam int POS_INT4  = 4;
	localparam int POS_INT5  = 5; // pin5_interrupt_select
	localparam int POS_TSEL  = 7; // tone_select
	localparam int POS_TEN   = 6; // tone_enable
	localparam int POS_FIXED = 5; // fixed_rate_select
	localparam int POS_VAR   = 4; // variable_rate_select

	// ==========================================================
	// fixed tone periods in system clock cycles
	localparam int DIV_SLOW = 2048;
	localparam int DIV_FAST = 1024;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum {REG_MODE1, REG_DIR, REG_DATA, REG_TONE, REG_EDGE, REG_NONE} ptm_reg_t;

endpackage

//--- ptm_sync.sv
/*
 * two-flop synchroniser for a vector of asynchronous pin levels.
 * assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/1ps
module ptm_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// first stage is read by the second stage only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // ptm_sync

//--- ptm_tone.sv
/*
 * tone waveform for pin 5: fixed divisions of the system clock or a
 * toggle per overflow of the companion timer.
 * assumes timer_ovf is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module ptm_tone
	import ptm_pkg::*;
#(
	parameter int SLOW = DIV_SLOW,
	parameter int FAST = DIV_FAST
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic enable,
	input  wire logic fixed_rate,
	input  wire logic variable_rate,
	input  wire logic timer_ovf,
	// waveform
	output logic      tone
);
	localparam int CW = $clog2(SLOW);

	// both rates are taken from one binary counter, so only such pairs work
	if (SLOW != 2 * FAST || FAST < 2 || (SLOW & (SLOW - 1)) != 0) begin : g_bad_div
		$error("slow period must be a power of two and twice the fast one");
	end

	logic [CW-1:0] div_reg;
	logic [CW-1:0] div_next;
	logic          tone_next;

	// ==========================================================
	// divider cleared while off, so the wave always starts low
	assign div_next = enable ? div_reg + CW'(1) : '0; // [RULE18]
	assign tone_next = !enable ? 1'b0 : // [RULE14]
		variable_rate ? (tone ^ timer_ovf) : // [RULE17]
		fixed_rate ? div_next[CW-2] : // [RULE16]
		div_next[CW-1]; // [RULE15]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
			tone    <= 1'b0;
		end else begin
			div_reg <= div_next;
			tone    <= tone_next;
		end
	end
endmodule // ptm_tone

//--- ptm_port.sv
/*
 * port one pin logic: pin-function routing, direction and data latch,
 * tone mode, interrupt edge selection, all behind an axi4-lite slave.
 * assumes pin_in is asynchronous; timer_ovf comes from the same clock.
 */
// Overview of operation
// [RULE1] mode bit 0 routes pin 0 to interrupt
// [RULE2] pin 0 interrupt edge is selectable
// [RULE3] direction bit 1 output, 0 input
// [RULE4] direction write-only; bits 7,6,3,2 read 1
// [RULE5] direction resets to cc
// [RULE6] direction and latch act only on gpio pins
// [RULE7] output pins read back the latch
// [RULE8] input pins read back the pin level
// [RULE9] bits 7,6 always read pin level
// [RULE10] data bits 3,2 read 1; others reset 0
// [RULE11] tone mode resets 0f; low bits read 1
// [RULE12] pin 5 interrupt select overrides tone mode
// [RULE13] tone select 0 leaves pin 5 gpio
// [RULE14] tone selected but off drives low
// [RULE15] tone on, rates 0: clock over 2048
// [RULE16] fixed rate 1: clock over 1024
// [RULE17] variable rate: toggle per timer overflow
// [RULE18] free divider, half duty, starts low
`timescale 1ns/1ps
module ptm_port
	import ptm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// pins
	input  wire logic [7:0]        pin_in,
	output logic [7:0]             pin_out,
	output logic [7:0]             pin_oe,
	// companion timer
	input  wire logic              timer_ovf,
	// interrupt inputs towards the interrupt controller
	output logic                   external_interrupt_zero,
	output logic                   external_interrupt_one,
	output logic                   external_interrupt_four,
	output logic                   external_interrupt_five,
	output logic [3:0]             irq_rising_edge
);
	// the decoder reads the low eight address bits directly
	if (ADDR_W < 8) begin : g_bad_addr
		$error("address must cover all register offsets");
	end

	// ==========================================================
	// address decode, shared by the read and write paths
	function automatic ptm_reg_t reg_of(input logic [ADDR_W-1:0] a);
		logic [7:0] ofs;
		ofs = a[7:0];
		if (a[ADDR_W-1:2] > (ADDR_W-2)'(OFS_EDGE[7:2]))
			return REG_NONE;
		case (ofs & 8'hfc)
			OFS_MODE1: return REG_MODE1;
			OFS_DIR:   return REG_DIR;
			OFS_DATA:  return REG_DATA;
			OFS_TONE:  return REG_TONE;
			OFS_EDGE:  return REG_EDGE;
			default:   return REG_NONE;
		endcase
	endfunction

	// ==========================================================
	// registers
	logic [7:0] mode1_reg;
	logic [7:0] dir_reg;
	logic [7:0] data_reg;
	logic [7:0] tone_reg;
	logic [7:0] edge_reg;
	logic [7:0] pin_s;
	logic       tone_level;

	// ==========================================================
	// pin levels pass two flops before any use
	ptm_sync #(
		.WIDTH (8)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_in),
		.q   (pin_s)
	);

	// ==========================================================
	// write channel: address and data accepted in either order
	logic              aw_got_reg;
	logic              w_got_reg;
	logic [ADDR_W-1:0] awaddr_hold;
	logic [7:0]        wdata_hold;
	logic              wstrb_hold;
	logic              aw_fire;
	logic              w_fire;
	logic              aw_have;
	logic              w_have;
	logic              do_write;
	logic              bvalid_next;
	logic [ADDR_W-1:0] waddr;
	logic [7:0]        wbyte;
	logic              wlane;
	ptm_reg_t          wsel;

	assign aw_fire     = s_axi_awvalid && s_axi_awready;
	assign w_fire      = s_axi_wvalid && s_axi_wready;
	assign aw_have     = aw_got_reg || aw_fire;
	assign w_have      = w_got_reg || w_fire;
	assign do_write    = aw_have && w_have;
	assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
	assign waddr       = aw_got_reg ? awaddr_hold : s_axi_awaddr;
	assign wbyte       = w_got_reg ? wdata_hold : s_axi_wdata[7:0];
	assign wlane       = w_got_reg ? wstrb_hold : s_axi_wstrb[0];
	assign wsel        = reg_of(waddr);

	// ready drops once a half is held or a response is pending
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
		end else begin
			aw_got_reg    <= aw_have && !do_write;
			w_got_reg     <= w_have && !do_write;
			s_axi_awready <= !(aw_have && !do_write) && !bvalid_next;
			s_axi_wready  <= !(w_have && !do_write) && !bvalid_next;
			s_axi_bvalid  <= bvalid_next;
		end
	end

	// captured halves and the response code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awaddr_hold <= '0;
			wdata_hold  <= '0;
			wstrb_hold  <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_fire)
				awaddr_hold <= s_axi_awaddr;
			if (w_fire) begin
				wdata_hold <= s_axi_wdata[7:0];
				wstrb_hold <= s_axi_wstrb[0];
			end
			if (do_write)
				s_axi_bresp <= (wsel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
		end
	end

	// ==========================================================
	// register writes; only byte lane 0 carries data, fixed bits hold
	logic       wr_ok;
	logic [7:0] mode1_next;
	logic [7:0] dir_next;
	logic [7:0] data_next;
	logic [7:0] tone_next;
	logic [7:0] edge_next;

	assign wr_ok      = do_write && wlane;
	assign mode1_next = (mode1_reg & ~WR_MODE1) | (wbyte & WR_MODE1); // [RULE1]
	assign dir_next   = (dir_reg & ~WR_DIR) | (wbyte & WR_DIR); // [RULE3] [RULE4]
	assign data_next  = (data_reg & ~WR_DATA) | (wbyte & WR_DATA); // [RULE10]
	assign tone_next  = (tone_reg & ~WR_TONE) | (wbyte & WR_TONE); // [RULE11]
	assign edge_next  = (edge_reg & ~WR_EDGE) | (wbyte & WR_EDGE); // [RULE2]

	// reset values fix reserved bits for good: ones, except zeros in edge and data bits 7,6
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode1_reg <= RST_MODE1;
			dir_reg   <= RST_DIR; // [RULE5]
			data_reg  <= RST_DATA; // [RULE10]
			tone_reg  <= RST_TONE; // [RULE11]
			edge_reg  <= RST_EDGE;
		end else if (wr_ok) begin
			if (wsel == REG_MODE1)
				mode1_reg <= mode1_next;
			if (wsel == REG_DIR)
				dir_reg <= dir_next;
			if (wsel == REG_DATA)
				data_reg <= data_next;
			if (wsel == REG_TONE)
				tone_reg <= tone_next;
			if (wsel == REG_EDGE)
				edge_reg <= edge_next;
		end
	end

	// ==========================================================
	// read channel: answer one cycle after the address is taken
	logic       ar_fire;
	logic       rvalid_next;
	logic [7:0] data_rd;
	logic [7:0] rd_byte;
	ptm_reg_t   rsel;

	assign ar_fire     = s_axi_arvalid && s_axi_arready;
	assign rvalid_next = ar_fire || (s_axi_rvalid && !s_axi_rready);
	assign rsel        = reg_of(s_axi_araddr);

	// output pins show the latch, input pins their level
	assign data_rd = (WR_DATA & ((dir_reg & data_reg) // [RULE7]
		| (~dir_reg & pin_s))) // [RULE8]
		| (IN_ONLY & pin_s) // [RULE9]
		| RST_DATA; // [RULE10]

	assign rd_byte =
		(rsel == REG_MODE1) ? mode1_reg :
		(rsel == REG_DIR)   ? DIR_RD : // [RULE4]
		(rsel == REG_DATA)  ? data_rd :
		(rsel == REG_TONE)  ? tone_reg :
		(rsel == REG_EDGE)  ? edge_reg : 8'h00;

	// a read has no side effect, so data is sampled once at the taking edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !rvalid_next;
			s_axi_rvalid  <= rvalid_next;
			if (ar_fire) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= (rsel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
			end
		end
	end

	// ==========================================================
	// tone generator
	logic tone_sel;
	logic tone_on;

	assign tone_sel = tone_reg[POS_TSEL];
	assign tone_on  = tone_sel && tone_reg[POS_TEN] && !mode1_reg[POS_INT5];

	ptm_tone u_tone (
		.clk           (clk),
		.rst           (rst),
		.enable        (tone_on),
		.fixed_rate    (tone_reg[POS_FIXED]),
		.variable_rate (tone_reg[POS_VAR]),
		.timer_ovf     (timer_ovf),
		.tone          (tone_level)
	);

	// ==========================================================
	// pin function routing
	logic [7:0] gpio_sel;
	logic [7:0] tone_pin;
	logic       tone_drive;
	logic [7:0] oe_next;
	logic [7:0] out_next;

	// interrupt select wins on pin 5; tone select takes it from gpio
	assign tone_drive = tone_sel && !mode1_reg[POS_INT5]; // [RULE12]
	assign gpio_sel = {2'b00,
		!mode1_reg[POS_INT5] && !tone_sel, // [RULE13]
		!mode1_reg[POS_INT4], 2'b00,
		!mode1_reg[POS_INT1],
		!mode1_reg[POS_INT0]}; // [RULE1]
	assign tone_pin = {2'b00, tone_drive, 5'b00000};

	assign oe_next  = (gpio_sel & dir_reg) | tone_pin; // [RULE6] [RULE3]
	assign out_next = (gpio_sel & data_reg & WR_DATA) // [RULE6]
		| (tone_pin & {8{tone_level}}); // [RULE14]

	// pins driven from flops to keep the pads glitch free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_oe  <= '0;
			pin_out <= '0;
		end else begin
			pin_oe  <= oe_next;
			pin_out <= out_next;
		end
	end

	// ==========================================================
	// interrupt inputs idle high when not routed, as they are active low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			external_interrupt_zero <= 1'b1;
			external_interrupt_one  <= 1'b1;
			external_interrupt_four <= 1'b1;
			external_interrupt_five <= 1'b1;
			irq_rising_edge         <= '0;
		end else begin
			external_interrupt_zero <= !mode1_reg[POS_INT0] || pin_s[0]; // [RULE1]
			external_interrupt_one  <= !mode1_reg[POS_INT1] || pin_s[1];
			external_interrupt_four <= !mode1_reg[POS_INT4] || pin_s[4];
			external_interrupt_five <= !mode1_reg[POS_INT5] || pin_s[5]; // [RULE12]
			irq_rising_edge <= {edge_reg[5], edge_reg[4], edge_reg[1], edge_reg[0]}; // [RULE2]
		end
	end

endmodule // ptm_port

//--- ptm_port_properties.sv
/*
 * concurrent checks on the ports of ptm_port: bus answers and holds,
 * unused pins never driven, interrupt inputs zero and five idle while their pin drives.
 * assumes one clock domain with rst, attached by the bind below.
 */
`timescale 1ns/1ps
module ptm_port_properties (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins and interrupts
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic        external_interrupt_zero,
	input wire logic        external_interrupt_five
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// bus answers: fixed one-cycle latency, held until taken
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response late");
	ready_return_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write ready not restored");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read upper bits set");

	// ==========================================================
	// pins: input-only places stay released, routed pins 0 and 5 never drive
	pins_idle_a: assert property ((pin_oe & 8'hcc) == 8'h00 && (pin_out & 8'hcc) == 8'h00)
		else $error("reserved pin driven");
	int_zero_route_a: assert property (pin_oe[0] |-> external_interrupt_zero)
		else $error("pin 0 driven while routed");
	int_five_route_a: assert property (pin_oe[5] |-> external_interrupt_five)
		else $error("pin 5 driven while routed");
endmodule // ptm_port_properties

bind ptm_port ptm_port_properties u_props (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.pin_out, .pin_oe, .external_interrupt_zero, .external_interrupt_five);

//--- ptm_port_bench.sv
/*
 * self-checking bench for ptm_port: registers over axi4-lite, pin
 * drive and read-back, interrupt routing and tone timing.
 * assumes the package, design and checker are compiled first.
 */
`timescale 1ns/1ps
module ptm_port_bench
	import ptm_pkg::*;
;
	// ==========================================================
	// signals
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_in = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb = 4'h0, irq_rising_edge;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer_ovf = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [7:0]  pin_out, pin_oe;
	logic        external_interrupt_zero, external_interrupt_one, v;
	logic        external_interrupt_four, external_interrupt_five;
	logic [7:0]  tones [4] = '{8'hc0, 8'he0, 8'hd0, 8'hf0};
	int          divs [4] = '{DIV_SLOW, DIV_FAST, 0, 0};
	int          errors = 0;
	int          total_checks = 0;

	ptm_port u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .timer_ovf,
		.external_interrupt_zero, .external_interrupt_one, .external_interrupt_four,
		.external_interrupt_five, .irq_rising_edge);

	// clock; inputs move only by non-blocking assignment on its rising edge
	always #4 clk = ~clk;

	// ==========================================================
	// compares and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic pchk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		chk({24'h0, got}, {24'h0, exp}, msg);
	endtask

	// each channel is released once its own ready is seen with valid high
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
		int n;
		@(posedge clk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (s_axi_bvalid !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t write response timed out", $time);
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (s_axi_rvalid !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t read data timed out", $time);
		end
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		rd(a);
		chk(rdat, {24'h0, exp}, msg);
		pchk({6'h0, resp}, {6'h0, RESP_OKAY}, msg);
	endtask

	// high time and full period of the tone, measured between edges
	task automatic period(input int exp);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		while (pin_out[5] !== 1'b1) @(posedge clk);
		while (pin_out[5] === 1'b1) begin
			@(posedge clk);
			hi++;
		end
		while (pin_out[5] === 1'b0) begin
			@(posedge clk);
			lo++;
		end
		chk(hi, exp / 2, "tone high time");
		chk(hi + lo, exp, "tone period");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// watchdog: the tone periods dominate, well under 20000 cycles
	initial begin
		#(8 * 40000);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		pin_in <= 8'ha5;
		repeat (5) @(posedge clk);
		rchk(OFS_MODE1, 8'h0c, "mode reset");
		rchk(OFS_DIR, 8'hff, "direction reads ones");
		rchk(OFS_TONE, 8'h0f, "tone reset");
		rchk(OFS_DATA, 8'had, "input pins read");
		pchk(pin_oe, 8'h00, "all pins input");
		$display("test reset done");
		// latch reset, output read-back, strobe-less write, mixed directions
		wr(OFS_DIR, 8'hff);
		pin_in <= 8'hff;
		repeat (5) @(posedge clk);
		rchk(OFS_DATA, 8'hcc, "latch reset");
		wr(OFS_DATA, 8'hff);
		pin_in <= 8'h00;
		repeat (5) @(posedge clk);
		pchk(pin_oe, 8'h33, "outputs on");
		pchk(pin_out & pin_oe, 8'h33, "latch driven");
		rchk(OFS_DATA, 8'h3f, "latch read back");
		wr(OFS_DATA, 8'h00, 4'h0);
		wr(OFS_DIR, 8'h12);
		pin_in <= 8'hc0;
		repeat (5) @(posedge clk);
		pchk(pin_oe, 8'h12, "mixed directions");
		rchk(OFS_DATA, 8'hde, "mixed read back");
		$display("test port done");
		// interrupt routing overrides direction and tone
		wr(OFS_TONE, 8'hf0);
		rchk(OFS_TONE, 8'hff, "tone low bits");
		wr(OFS_MODE1, 8'h33);
		rchk(OFS_MODE1, 8'h3f, "mode read back");
		pin_in <= 8'h00;
		repeat (5) @(posedge clk);
		pchk(pin_oe, 8'h00, "routed pins released");
		pchk({4'h0, external_interrupt_five, external_interrupt_four, external_interrupt_one,
			external_interrupt_zero}, 8'h00, "interrupts low");
		pin_in <= 8'h33;
		repeat (5) @(posedge clk);
		pchk({4'h0, external_interrupt_five, external_interrupt_four, external_interrupt_one,
			external_interrupt_zero}, 8'h0f, "interrupts high");
		wr(OFS_EDGE, 8'h33);
		repeat (2) @(posedge clk);
		pchk({4'h0, irq_rising_edge}, 8'h0f, "rising edges");
		wr(OFS_EDGE, 8'h01);
		repeat (2) @(posedge clk);
		pchk({4'h0, irq_rising_edge}, 8'h01, "falling edges");
		wr(OFS_MODE1, 8'h00);
		$display("test routing done");
		// tone modes on pin 5
		wr(OFS_DIR, 8'h20);
		wr(OFS_DATA, 8'h20);
		wr(OFS_TONE, 8'h70);
		repeat (2) @(posedge clk);
		pchk(pin_out & pin_oe, 8'h20, "pin 5 stays port");
		wr(OFS_TONE, 8'h80);
		repeat (2) @(posedge clk);
		pchk(pin_oe & 8'h20, 8'h20, "tone pin driven");
		pchk(pin_out & 8'h20, 8'h00, "tone off low");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_TONE, 8'h80);
			wr(OFS_TONE, tones[i]);
			repeat (400) @(posedge clk);
			if (divs[i] != 0) begin
				pchk(pin_out & 8'h20, 8'h00, "tone starts low");
				period(divs[i]);
			end else begin
				v = pin_out[5];
				timer_ovf <= 1'b1;
				@(posedge clk);
				timer_ovf <= 1'b0;
				repeat (4) @(posedge clk);
				pchk({7'h0, pin_out[5]}, {7'h0, ~v}, "toggle on overflow");
				repeat (20) @(posedge clk);
				pchk({7'h0, pin_out[5]}, {7'h0, ~v}, "held between overflows");
			end
		end
		$display("test tone done");
		// unmapped place
		wr(8'h20, 8'hff);
		pchk({6'h0, resp}, {6'h0, RESP_DECERR}, "unmapped write");
		rd(8'h20);
		chk(rdat, 32'h0, "unmapped read data");
		pchk({6'h0, resp}, {6'h0, RESP_DECERR}, "unmapped read");
		$display("test unmapped done");
		finish_test();
	end
endmodule // ptm_port_bench
